// file: src/cfe_map.svh
/*
  Register offsets, field positions, reset values and status bit positions of the forwarding engine.
  Assumes it is included by its bare name from each file that needs it.
*/
`ifndef CFE_MAP_SVH
`define CFE_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CFE_ADDR_PORT_MAP 8'h20
`define CFE_ADDR_MODE 8'h21
`define CFE_ADDR_STATUS 8'h22

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CFE_RST_PORT_MAP 8'h00
`define CFE_RST_MODE 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFE_DIS_LSB 0
`define CFE_MAP_LSB 4
`define CFE_RR_LSB 0
`define CFE_SYNC_LSB 2
`define CFE_SYNC_W 2
`define CFE_ST_SYNCED 0
`define CFE_ST_LOST 1
`define CFE_ST_HS 2

`endif

// file: src/cfe_pkg.sv
/*
  Types shared by the forwarding engine and its bench: packet kinds, modes, states and carriers.
  Assumes nothing of its surroundings.
*/
package cfe_pkg;

  localparam int CFE_NPORT = 4;

  // packet kind as presented by a video buffer head
  typedef enum logic [1:0] {
    K_FS = 2'h0,
    K_FE = 2'h1,
    K_LINE = 2'h2
  } cfe_kind_e;

  // synchronized sub-mode codes in the mode register
  typedef enum logic [1:0] {
    SM_OFF = 2'h0,
    SM_BASIC = 2'h1,
    SM_ILV = 2'h2,
    SM_CONCAT = 2'h3
  } cfe_sync_e;

  // forwarding mode in force
  typedef enum logic [1:0] {
    MD_RR = 2'h0,
    MD_BASIC = 2'h1,
    MD_ILV = 2'h2
  } cfe_mode_e;

  // scheduler states
  typedef enum logic [1:0] {
    ST_PICK = 2'b01,
    ST_MOVE = 2'b10
  } cfe_state_e;

  // head word of one video buffer
  typedef struct packed {
    logic avail;
    logic last;
    cfe_kind_e kind;
    logic [1:0] vc;
    logic [15:0] data;
  } cfe_port_s;

  // word handed to the transmitter
  typedef struct packed {
    logic sop;
    logic eop;
    cfe_kind_e kind;
    logic [1:0] vc;
    logic [15:0] data;
  } cfe_word_s;

endpackage

// file: src/cfe_engine.sv
/*
  Forwarding engine: pulls packets from four video buffers, schedules them in round-robin,
  basic synchronized or line-interleaved order, and queues them for the transmitter.
  Assumes buffer heads on ref_clk, a register port on ref_clk and a transmitter word clock from outside.
*/
// How it works
// - buffer packets go out through the queue; hs flag marks high-speed bursts
// - buffer heads are watched every cycle to decide what can go next
// - a port whose disable bit is set is never served
// - map bits pick which buffers this engine serves, one engine per buffer
// - each engine instance decodes its own fields and runs alone
// - round-robin mode sends ready packets at once, round-robin by port
// - round-robin mode imposes no ordering; vc and kind pass untouched
// - the engine's round-robin bit selects best-effort mode
// - synchronized rounds send frame starts and lines in port order zero to three
// - on sync loss drop packets and hunt for the next frame start
// - synced status bit follows the round state; sticky lost flag cleared by a status read
// - sub-mode field picks basic or interleaved forwarding; the concatenated code runs basic order
// - basic mode sends every frame whole, each packet with its port's vc
// - basic mode ends with last lines then frame ends in port order
// - interleaved mode keeps only the first frame start and frame end
// - interleaved mode never checks that all ports share one vc
// - mode value 0x14 selects basic synchronized forwarding
// - mode value 0x28 selects line-interleaved forwarding
// - port map value 0x00 forwards all ports to engine 0, none to engine 1
// - a packet is started only once its buffer reports it whole
// - synced bit reads zero whenever synchronized forwarding is off
`timescale 1ns/1ns
`include "cfe_map.svh"

// ----------------------------------------------------------------
// word queue between scheduler and transmitter
// ----------------------------------------------------------------
module cfe_fifo #(
  parameter int W = 22,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic do_wr;
  logic do_rd;

  // extra pointer bit tells full from empty; depth must be a power of two
  assign in_ready = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  assign do_wr = ce && in_valid && in_ready;
  assign do_rd = ce && out_ready && out_valid;

  // storage has no reset: contents are never read while empty
  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// forwarding engine top
// ----------------------------------------------------------------
module cfe_engine #(
  parameter bit ENGINE_ID = 1'b0,
  parameter int WAIT_LIMIT = 1024,
  parameter int QDEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire cfe_pkg::cfe_port_s [3:0] port_in,
  output logic [3:0] port_pop,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tx_clk,
  output cfe_pkg::cfe_word_s tx_word,
  output logic tx_valid,
  output logic tx_hs
);
  import cfe_pkg::*;

  logic [7:0] ctl_map_r;
  logic [7:0] ctl_mode_r;
  logic [7:0] reg_rdata_r;
  cfe_mode_e mode_r;
  cfe_mode_e mode_nxt;
  cfe_state_e st_r;
  logic [1:0] cur_r;
  logic drop_r;
  logic sop_r;
  logic mv_wait_r;
  logic [3:0] port_pop_r;
  logic [1:0] rr_ptr_r;
  logic [3:0] rnd_r;
  cfe_kind_e rk_r;
  logic first_r;
  logic sp_run_r;
  logic synced_r;
  logic lost_r;
  logic [15:0] wait_cnt_r;
  logic tx_s1_r;
  logic tx_s2_r;
  logic tx_s3_r;
  logic tx_lvl_r;
  cfe_word_s tx_word_r;
  logic tx_valid_r;
  logic tx_hs_r;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic [3:0] dis;
  logic [3:0] map;
  logic rr_bit;
  cfe_sync_e sync_code;
  logic wr_map;
  logic wr_mode;
  logic rd_clr;
  logic synced_vis;

  // each engine reads its own bit and field, so instances never interact
  assign dis = ctl_map_r[`CFE_DIS_LSB +: 4];
  assign map = ctl_map_r[`CFE_MAP_LSB +: 4];
  assign rr_bit = ctl_mode_r[`CFE_RR_LSB + ENGINE_ID];
  assign sync_code = cfe_sync_e'(ctl_mode_r[`CFE_SYNC_LSB + `CFE_SYNC_W * ENGINE_ID +: `CFE_SYNC_W]);
  // concatenation is not built here and falls back to basic order
  assign mode_nxt = (rr_bit || sync_code == SM_OFF) ? MD_RR : (sync_code == SM_ILV ? MD_ILV : MD_BASIC);
  assign wr_map = ce && reg_wr && reg_addr == `CFE_ADDR_PORT_MAP;
  assign wr_mode = ce && reg_wr && reg_addr == `CFE_ADDR_MODE;
  assign rd_clr = ce && reg_rd && reg_addr == `CFE_ADDR_STATUS;
  // a pending switch to round-robin already hides the synced bit before the boundary
  assign synced_vis = synced_r && mode_r != MD_RR && mode_nxt != MD_RR;

  // ----------------------------------------------------------------
  // per-port head decode
  // ----------------------------------------------------------------
  logic [3:0] act;
  logic [3:0] head_ok;
  logic [3:0] is_fs;
  logic [3:0] is_fe;
  logic [3:0] is_line;

  genvar gi;
  generate
    for (gi = 0; gi < CFE_NPORT; gi++) begin : g_port
      // served only when mapped here and not disabled
      assign act[gi] = !dis[gi] && (map[gi] == ENGINE_ID);
      // avail means the whole packet sits in the buffer
      assign head_ok[gi] = port_in[gi].avail && act[gi];
      assign is_fs[gi] = port_in[gi].kind == K_FS;
      assign is_fe[gi] = port_in[gi].kind == K_FE;
      assign is_line[gi] = port_in[gi].kind == K_LINE;
    end
  endgenerate

  // first requesting port at or after the pointer
  function automatic logic [2:0] rr_pick(input logic [3:0] req, input logic [1:0] ptr);
    logic [2:0] r;
    logic [1:0] idx;
    r = 3'h0;
    for (int k = 3; k >= 0; k--) begin
      idx = ptr + 2'(k);
      if (req[idx]) begin
        r = {1'b1, idx};
      end
    end
    return r;
  endfunction

  // lowest requesting port
  function automatic logic [1:0] lo_pick(input logic [3:0] req);
    logic [1:0] r;
    r = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (req[k]) begin
        r = 2'(k);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // scheduling decisions
  // ----------------------------------------------------------------
  logic pick_go;
  logic in_rr;
  logic rnd_busy;
  logic all_ready;
  logic all_fs;
  logic all_fe;
  logic all_line;
  logic [3:0] hunt_bad;
  logic [2:0] rr_sel;
  logic [1:0] rnd_low;
  logic waiting;
  logic mixed;
  logic loss_ev;
  logic start_round;
  logic send_rr;
  logic send_rnd;
  logic send_hunt;
  logic launch;
  logic [1:0] launch_port;
  logic launch_drop;
  logic mode_chg;
  logic pick_run;

  assign pick_go = ce && st_r == ST_PICK && !mv_wait_r;
  // the pick cycle that takes a new mode launches nothing, so the old mode never sends again
  assign pick_run = pick_go && !mode_chg;
  assign in_rr = mode_r == MD_RR;
  assign rnd_busy = rnd_r != 4'h0;
  assign all_ready = act != 4'h0 && head_ok == act;
  assign all_fs = all_ready && (is_fs | ~act) == 4'hF;
  assign all_fe = all_ready && (is_fe | ~act) == 4'hF;
  assign all_line = all_ready && (is_line | ~act) == 4'hF;
  assign hunt_bad = head_ok & ~is_fs;
  assign rr_sel = rr_pick(head_ok, rr_ptr_r);
  assign rnd_low = lo_pick(rnd_r);
  // a source that lags too long or disagrees in kind breaks sync
  assign waiting = !in_rr && sp_run_r && (rnd_busy ? !head_ok[rnd_low] : !all_ready);
  assign mixed = !in_rr && sp_run_r && !rnd_busy && all_ready && !(all_fs || all_fe || all_line);
  assign loss_ev = pick_run && ((waiting && wait_cnt_r == 16'(WAIT_LIMIT - 1)) || mixed);
  // a round starts only when every active port shows the same kind
  assign start_round = pick_run && !in_rr && !rnd_busy &&
                       ((sp_run_r && all_ready && !mixed) || (!sp_run_r && hunt_bad == 4'h0 && all_fs));
  assign send_rr = pick_run && in_rr && rr_sel[2];
  assign send_rnd = pick_run && !in_rr && rnd_busy && head_ok[rnd_low];
  assign send_hunt = pick_run && !in_rr && !sp_run_r && !rnd_busy && hunt_bad != 4'h0;
  assign launch = send_rr || send_rnd || send_hunt;
  assign launch_port = send_rr ? rr_sel[1:0] : (send_rnd ? rnd_low : lo_pick(hunt_bad));
  // interleaved keeps the first start and end of a round, vc never checked
  assign launch_drop = send_hunt || (send_rnd && mode_r == MD_ILV && rk_r != K_LINE && !first_r);
  // mode is taken only between packets and between rounds
  assign mode_chg = pick_go && !rnd_busy && mode_nxt != mode_r;

  // ----------------------------------------------------------------
  // packet mover
  // ----------------------------------------------------------------
  logic q_in_ready;
  logic q_in_valid;
  cfe_word_s q_in_word;
  logic q_out_valid;
  cfe_word_s q_out_word;
  logic mv_take;
  logic tx_edge;

  // a take is followed by one idle cycle so the buffer head can advance after the pop
  assign mv_take = ce && st_r == ST_MOVE && !mv_wait_r && (drop_r || q_in_ready);
  assign q_in_valid = mv_take && !drop_r;
  // vc and kind come from the port, so every packet keeps its port's channel
  assign q_in_word = '{sop: sop_r, eop: port_in[cur_r].last, kind: port_in[cur_r].kind,
                       vc: port_in[cur_r].vc, data: port_in[cur_r].data};

  cfe_fifo #(
    .W($bits(cfe_word_s)),
    .DEPTH(QDEPTH)
  ) u_queue (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(ce),
    .in_valid(q_in_valid),
    .in_ready(q_in_ready),
    .in_data(q_in_word),
    .out_valid(q_out_valid),
    .out_ready(tx_edge),
    .out_data(q_out_word)
  );

  // registers: software writes steer mode and port selection
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_map_r <= `CFE_RST_PORT_MAP;
      ctl_mode_r <= `CFE_RST_MODE;
      reg_rdata_r <= 8'h00;
    end else if (ce) begin
      if (wr_map) begin
        ctl_map_r <= reg_wdata;
      end
      if (wr_mode) begin
        ctl_mode_r <= reg_wdata;
      end
      if (reg_rd) begin
        unique case (reg_addr)
          `CFE_ADDR_PORT_MAP: reg_rdata_r <= ctl_map_r;
          `CFE_ADDR_MODE: reg_rdata_r <= ctl_mode_r;
          `CFE_ADDR_STATUS: reg_rdata_r <= 8'({tx_hs_r, lost_r, synced_vis});
          default: reg_rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // mover state: one packet is moved whole before the next pick
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= ST_PICK;
      cur_r <= 2'h0;
      drop_r <= 1'b0;
      sop_r <= 1'b0;
      mv_wait_r <= 1'b0;
      port_pop_r <= 4'h0;
    end else if (ce) begin
      mv_wait_r <= mv_take;
      port_pop_r <= mv_take ? 4'(1) << cur_r : 4'h0;
      if (launch) begin
        st_r <= ST_MOVE;
        cur_r <= launch_port;
        drop_r <= launch_drop;
        sop_r <= 1'b1;
      end else if (mv_take) begin
        sop_r <= 1'b0;
        if (port_in[cur_r].last) begin
          st_r <= ST_PICK;
        end
      end
    end
  end

  // round-robin pointer moves past the served port
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rr_ptr_r <= 2'h0;
    end else if (ce && send_rr) begin
      rr_ptr_r <= rr_sel[1:0] + 2'h1;
    end
  end

  // synchronized rounds: ports leave the round mask in ascending order
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_r <= MD_RR;
      rnd_r <= 4'h0;
      rk_r <= K_FS;
      first_r <= 1'b0;
      sp_run_r <= 1'b0;
      synced_r <= 1'b0;
      wait_cnt_r <= 16'h0000;
    end else if (ce) begin
      if (mode_chg) begin
        mode_r <= mode_nxt;
        sp_run_r <= 1'b0;
        synced_r <= 1'b0;
      end else if (loss_ev) begin
        sp_run_r <= 1'b0;
        synced_r <= 1'b0;
        rnd_r <= 4'h0;
        wait_cnt_r <= 16'h0000;
      end else if (start_round) begin
        rnd_r <= act;
        rk_r <= all_fs ? K_FS : (all_fe ? K_FE : K_LINE);
        first_r <= 1'b1;
        sp_run_r <= 1'b1;
        synced_r <= 1'b1;
        wait_cnt_r <= 16'h0000;
      end else if (send_rnd) begin
        rnd_r[rnd_low] <= 1'b0;
        first_r <= 1'b0;
        wait_cnt_r <= 16'h0000;
      end else if (pick_run && waiting) begin
        wait_cnt_r <= wait_cnt_r + 16'h0001;
      end
    end
  end

  // sticky loss flag: a new loss wins over the read that clears it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lost_r <= 1'b0;
    end else if (ce) begin
      lost_r <= loss_ev || (lost_r && !rd_clr);
    end
  end

  // ----------------------------------------------------------------
  // transmitter side
  // ----------------------------------------------------------------
  // word clock edge counts once the second and third stages agree
  assign tx_edge = ce && tx_s2_r == tx_s3_r && tx_s3_r && !tx_lvl_r;

  // word clock synchroniser
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_s1_r <= 1'b0;
      tx_s2_r <= 1'b0;
      tx_s3_r <= 1'b0;
      tx_lvl_r <= 1'b0;
    end else if (ce) begin
      tx_s1_r <= tx_clk;
      tx_s2_r <= tx_s1_r;
      tx_s3_r <= tx_s2_r;
      if (tx_s2_r == tx_s3_r) begin
        tx_lvl_r <= tx_s3_r;
      end
    end
  end

  // one word per word clock edge; hs holds until a packet's end drains
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_word_r <= '0;
      tx_valid_r <= 1'b0;
      tx_hs_r <= 1'b0;
    end else if (ce) begin
      if (tx_edge) begin
        if (q_out_valid) begin
          tx_word_r <= q_out_word; // an idle rise keeps the last word, never an empty slot
        end
        tx_valid_r <= q_out_valid;
        tx_hs_r <= q_out_valid || (tx_hs_r && !tx_word_r.eop);
      end else begin
        tx_valid_r <= 1'b0;
      end
    end
  end

  assign port_pop = port_pop_r;
  assign reg_rdata = reg_rdata_r;
  assign tx_word = tx_word_r;
  assign tx_valid = tx_valid_r;
  assign tx_hs = tx_hs_r;
endmodule

// file: verif/cfe_engine_chk.sv
/*
  Port checker of the forwarding engine.
  Assumes it is bound onto cfe_engine and sees only its ports.
*/
`timescale 1ns/1ns
module cfe_engine_chk #(
  parameter bit ENGINE_ID = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire cfe_pkg::cfe_port_s [3:0] port_in,
  input wire logic [3:0] port_pop,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_clk,
  input wire cfe_pkg::cfe_word_s tx_word,
  input wire logic tx_valid,
  input wire logic tx_hs
);
  import cfe_pkg::*;
  // ----------------
  // control shadow
  // ----------------
  logic [7:0] map_r;
  logic [7:0] mode_r;
  wire logic [3:0] avail_w = {port_in[3].avail, port_in[2].avail, port_in[1].avail, port_in[0].avail};
  // a map bit unlike our id hands the buffer to the other engine
  wire logic [3:0] blocked_w = map_r[3:0] | (ENGINE_ID ? ~map_r[7:4] : map_r[7:4]);
  // only writes with ce high land, as in the engine
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      map_r <= 8'h00;
      mode_r <= 8'h00;
    end else if (ce && reg_wr && reg_addr == 8'h20) begin
      map_r <= reg_wdata;
    end else if (ce && reg_wr && reg_addr == 8'h21) begin
      mode_r <= reg_wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------
  // properties
  // ----------------
  a_pop_onehot: assert property ($onehot0(port_pop)) else $error("two ports popped at once");
  a_pop_gap: assert property (|port_pop |=> port_pop == 4'h0) else $error("pops not spaced");
  // the head has already moved on when the pop shows, so look at the take cycle
  a_pop_whole: assert property (|port_pop |-> |(port_pop & $past(avail_w))) else $error("pop of absent packet");
  a_pop_blocked: assert property ((port_pop & blocked_w) == 4'h0) else $error("blocked port popped");
  a_tx_pulse: assert property (tx_valid |=> !tx_valid) else $error("word pulse too long");
  a_tx_burst: assert property (tx_valid |-> tx_hs) else $error("word outside burst");
  a_word_hold: assert property (!tx_valid |-> $stable(tx_word)) else $error("word moved without pulse");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
  a_mode_back: assert property (ce && reg_wr && reg_addr == 8'h21 ##2 ce && reg_rd && reg_addr == 8'h21
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("mode read-back wrong");
  a_sync_off: assert property (mode_r[3:2] == 2'h0 && ce && reg_rd && reg_addr == 8'h22
    |=> !reg_rdata[0]) else $error("synced while sync off");
  c_fs_out: cover property (tx_valid && tx_word.sop && tx_word.kind == K_FS);
  c_lost: cover property (reg_rd && reg_addr == 8'h22 ##1 reg_rdata[1]);
  c_pop_last: cover property (port_pop[3]);
endmodule
bind cfe_engine cfe_engine_chk #(.ENGINE_ID(ENGINE_ID)) cfe_engine_chk_inst (
  .ref_clk(ref_clk), .reset(reset), .ce(ce), .port_in(port_in), .port_pop(port_pop),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_clk(tx_clk), .tx_word(tx_word), .tx_valid(tx_valid), .tx_hs(tx_hs)
);

// file: verif/cfe_rx_model.sv
/*
  Receiver model at the transmitter side: makes the word clock and keeps every word.
  Assumes the engine's tx port and a run request from the bench.
*/
`timescale 1ns/1ns
module cfe_rx_model (
  input wire logic ref_clk,
  input wire logic run,
  input wire cfe_pkg::cfe_word_s tx_word,
  input wire logic tx_valid,
  output logic tx_clk
);
  import cfe_pkg::*;
  cfe_word_s got[$];
  // ----------------
  // word clock
  // ----------------
  // 400 ns clock, odd start phase, resting low between transfers
  initial begin
    tx_clk = 1'b0;
    #7;
    forever begin
      if (run) begin
        #200;
        tx_clk = ~tx_clk;
      end else begin
        tx_clk = 1'b0;
        @(posedge run);
      end
    end
  end
  // no push back exists, so every pulse is a word taken
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1) begin
      got.push_back(tx_word);
    end
  end
endmodule

// file: verif/test_csi2_forwarding_engine.sv
/*
  Self-checking bench of the forwarding engine: registers, round-robin, basic and
  interleaved synchronized forwarding, sync loss. Assumes package, design, checker, receiver model.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module test_csi2_forwarding_engine;
  import cfe_pkg::*;
  logic ref_clk, reset, reg_wr, reg_rd, run, tx_clk, tx_valid, tx_hs;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] port_pop;
  cfe_port_s [3:0] port_in;
  cfe_word_s tx_word;
  cfe_port_s bq[4][$];
  cfe_word_s exp_q[$];
  logic [7:0] codes[4] = '{8'h14, 8'h28, 8'h3C, 8'h00};
  int err_count, n_tests, cyc;
  // ----------------
  // design and partner
  // ----------------
  cfe_engine #(.ENGINE_ID(1'b0), .WAIT_LIMIT(16), .QDEPTH(16)) cfe_engine_inst (
    .ref_clk(ref_clk), .reset(reset), .ce(1'b1), .port_in(port_in), .port_pop(port_pop),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_clk(tx_clk), .tx_word(tx_word), .tx_valid(tx_valid), .tx_hs(tx_hs));
  cfe_rx_model cfe_rx_model_inst (.ref_clk(ref_clk), .run(run), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_clk(tx_clk));
  initial begin
    ref_clk = 1'b0;
    forever begin
      #25;
      ref_clk = ~ref_clk;
    end
  end
  // hang guard, far above the thousand or fewer cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // buffer heads; an empty buffer shows a pattern that changes every cycle
  task automatic refresh();
    for (int p = 0; p < 4; p++) begin
      port_in[p] = (bq[p].size() != 0) ? bq[p][0] : cfe_port_s'({1'b0, 21'(cyc)});
    end
  endtask
  always @(posedge ref_clk) begin
    #2;
    for (int p = 0; p < 4; p++) begin
      if (port_pop[p] === 1'b1 && bq[p].size() != 0) begin
        void'(bq[p].pop_front());
      end
    end
    refresh();
  end
  // ----------------
  // access tasks
  // ----------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #2;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #2;
    reg_rd = 1'b0;
    `CHK(reg_rdata & m, e)
  endtask
  // ld loads a whole packet into its buffer, ex expects it at the receiver
  task automatic pkt(input int p, input int id, input int nw, input cfe_kind_e k, input bit ld, input bit ex);
    logic [15:0] d;
    for (int w = 0; w < nw; w++) begin
      d = {4'(p), 4'(id), 8'(w)};
      if (ld) bq[p].push_back('{1'b1, w == nw - 1, k, 2'(p), d});
      if (ex) exp_q.push_back('{w == 0, w == nw - 1, k, 2'(p), d});
    end
    refresh();
  endtask
  // all four streams arrive aligned and alike; interleave keeps port 0 sync packets only
  task automatic frame(input bit ilv);
    for (int p = 0; p < 4; p++) pkt(p, 0, 1, K_FS, 1'b1, !ilv || p == 0);
    for (int p = 0; p < 4; p++) pkt(p, 1, 2, K_LINE, 1'b1, 1'b1);
    for (int p = 0; p < 4; p++) pkt(p, 9, 1, K_FE, 1'b1, !ilv || p == 0);
  endtask
  task automatic drain();
    int n;
    n = 0;
    run = 1'b1;
    while (cfe_rx_model_inst.got.size() < exp_q.size() && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (40) @(posedge ref_clk);
    #2;
    run = 1'b0;
    `CHK(cfe_rx_model_inst.got.size(), exp_q.size())
    `CHK(tx_hs, 1'b0)
    for (int i = 0; i < exp_q.size() && i < cfe_rx_model_inst.got.size(); i++) begin
      `CHK(cfe_rx_model_inst.got[i], exp_q[i])
    end
    cfe_rx_model_inst.got.delete();
    exp_q.delete();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    run = 1'b0;
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    refresh();
    repeat (20) @(posedge ref_clk);
    #2;
    reset = 1'b0;
    // reset values, every mode code read back, unmapped places
    rd(8'h20, 8'hFF, 8'h00);
    rd(8'h22, 8'hFF, 8'h00);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'hFF, 8'h00);
    rd(8'h20, 8'hFF, 8'h00);
    foreach (codes[i]) begin
      wr(8'h21, codes[i]);
      rd(8'h21, 8'hFF, codes[i]);
    end
    // round-robin with port 2 disabled and port 1 handed to the other engine
    wr(8'h21, 8'h01);
    wr(8'h20, 8'h24);
    for (int p = 0; p < 4; p++) pkt(p, 1, 2, K_LINE, 1'b1, p == 0 || p == 3);
    drain();
    `CHK(bq[1].size() + bq[2].size(), 4)
    bq[1].delete();
    bq[2].delete();
    refresh();
    // pointer wrapped to port 0: a second port 0 packet must wait behind port 1
    wr(8'h20, 8'h00);
    pkt(0, 2, 1, K_LINE, 1'b1, 1'b1);
    pkt(0, 3, 3, K_FE, 1'b1, 1'b0);
    pkt(1, 2, 1, K_FE, 1'b1, 1'b1);
    pkt(0, 3, 3, K_FE, 1'b0, 1'b1);
    drain();
    rd(8'h22, 8'h01, 8'h00);
    // basic synchronized; empty buffers afterwards time out into sync loss
    wr(8'h21, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h14);
    frame(1'b0);
    repeat (10) @(posedge ref_clk);
    rd(8'h22, 8'h03, 8'h01);
    drain();
    rd(8'h22, 8'h03, 8'h02);
    rd(8'h22, 8'h03, 8'h00);
    // line interleaved with unlike channels, which pass unchecked
    wr(8'h21, 8'h28);
    frame(1'b1);
    drain();
    // mixed kinds after a frame start: dropped until the next frame start
    wr(8'h21, 8'h14);
    for (int p = 0; p < 4; p++) pkt(p, 0, 1, K_FS, 1'b1, 1'b1);
    for (int p = 0; p < 4; p++) pkt(p, 5, 1, p < 2 ? K_LINE : K_FE, 1'b1, 1'b0);
    frame(1'b0);
    drain();
    rd(8'h22, 8'h02, 8'h02);
    tally_and_finish();
  end
endmodule
